/* core/chgevt_pkg.sv */
// Package: register map, field positions and reset values of the charger event block.
package chgevt_pkg;
  localparam logic [7:0] CHGEVT_ADDR_FLAGS = 8'hD0;
  localparam logic [7:0] CHGEVT_ADDR_MASK = 8'hD1;
  localparam logic [7:0] CHGEVT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] CHGEVT_MASK_RESET = 8'h00;
  // Bit 0 of both registers is reserved and reads as zero.
  localparam logic [7:0] CHGEVT_IMPL_BITS = 8'hFE;
  localparam int CHGEVT_BIT_BATOV = 1;
  localparam int CHGEVT_BIT_TEMP = 2;
  localparam int CHGEVT_BIT_DONE = 3;
  localparam int CHGEVT_BIT_INDET = 4;
  localparam int CHGEVT_BIT_BATTERY_PRESENCE_EVENT = 5;
  localparam int CHGEVT_BIT_ILIM = 6;
  localparam int CHGEVT_BIT_INOV = 7;
  localparam int CHGEVT_STATE_W = 4;
endpackage

/* core/chgevt_edge.sv */
// Edge detector for one level input: reports rising and falling edges on separate outputs.
`timescale 1ns/1ps
`default_nettype none
module chgevt_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic last_q;
  logic last_d;

  always_comb begin
    last_d = level;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 1'b0;
    end else begin
      last_q <= last_d;
    end
  end

  assign rise = level & ~last_q;
  assign fall = ~level & last_q;
endmodule // chgevt_edge
`default_nettype wire

/* core/chgevt_flags.sv */
// Charger event flag and mask registers with the masked interrupt output.
`timescale 1ns/1ps
`default_nettype none
module chgevt_flags
  import chgevt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic battery_overvoltage,
  input wire logic battery_temp_fault,
  input wire logic battery_above_float,
  input wire logic charge_current_below_eoc,
  input wire logic [CHGEVT_STATE_W-1:0] charger_state_field,
  input wire logic state_report_select,
  input wire logic input_source_valid,
  input wire logic battery_above_trickle,
  input wire logic input_current_limit,
  input wire logic input_overvoltage,
  output logic irq
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [CHGEVT_STATE_W-1:0] state_q;
  logic [CHGEVT_STATE_W-1:0] state_d;
  logic done_q;
  logic done_d;
  logic in_rise, in_fall, bat_rise, bat_fall;
  logic [7:0] events;
  logic done_now;
  logic rd_flags;

  chgevt_edge u_in_edge (
    .clk(clk), .rst(rst), .level(input_source_valid),
    .rise(in_rise), .fall(in_fall)
  );
  chgevt_edge u_bat_edge (
    .clk(clk), .rst(rst), .level(battery_above_trickle),
    .rise(bat_rise), .fall(bat_fall)
  );

  // Completion is taken on its rising edge so a steady done condition
  // cannot keep refilling the flag after software clears it.
  assign done_now = battery_above_float & charge_current_below_eoc;
  assign rd_flags = reg_rd && (reg_addr == CHGEVT_ADDR_FLAGS);

  always_comb begin
    events = 8'h00;
    events[CHGEVT_BIT_BATOV] = battery_overvoltage;
    events[CHGEVT_BIT_TEMP] = battery_temp_fault;
    if (state_report_select) begin
      events[CHGEVT_BIT_DONE] = (charger_state_field != state_q);
    end else begin
      events[CHGEVT_BIT_DONE] = done_now & ~done_q;
    end
    events[CHGEVT_BIT_INDET] = in_rise | in_fall;
    events[CHGEVT_BIT_BATTERY_PRESENCE_EVENT] = bat_rise | bat_fall;
    events[CHGEVT_BIT_ILIM] = input_current_limit;
    events[CHGEVT_BIT_INOV] = input_overvoltage;
  end

  always_comb begin
    state_d = charger_state_field;
    done_d = done_now;
    flags_d = rd_flags ? CHGEVT_FLAGS_RESET : flags_q;
    flags_d = (flags_d | events) & CHGEVT_IMPL_BITS;
    mask_d = mask_q;
    if (reg_wr && (reg_addr == CHGEVT_ADDR_MASK)) begin
      mask_d = reg_wdata & CHGEVT_IMPL_BITS;
    end
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        CHGEVT_ADDR_FLAGS: rdata_d = flags_q;
        CHGEVT_ADDR_MASK: rdata_d = mask_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= CHGEVT_FLAGS_RESET;
      mask_q <= CHGEVT_MASK_RESET;
      rdata_q <= 8'h00;
      state_q <= '0;
      done_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      done_q <= done_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = |(flags_q & ~mask_q);

  sequence s_read_flags;
    rd_flags;
  endsequence

  property p_batov_sets;
    @(posedge clk) disable iff (rst)
    battery_overvoltage |=> flags_q[CHGEVT_BIT_BATOV];
  endproperty
  a_batov_sets: assert property (p_batov_sets) else $error("batov flag not set");

  property p_temp_sets;
    @(posedge clk) disable iff (rst)
    battery_temp_fault |=> flags_q[CHGEVT_BIT_TEMP];
  endproperty
  a_temp_sets: assert property (p_temp_sets) else $error("temp flag not set");

  property p_state_change;
    @(posedge clk) disable iff (rst)
    state_report_select && (charger_state_field != $past(charger_state_field))
    |=> flags_q[CHGEVT_BIT_DONE];
  endproperty
  a_state_change: assert property (p_state_change) else $error("state change lost");

  property p_done_gate;
    @(posedge clk) disable iff (rst)
    !state_report_select && !done_now && !flags_q[CHGEVT_BIT_DONE]
    |=> !flags_q[CHGEVT_BIT_DONE];
  endproperty
  a_done_gate: assert property (p_done_gate) else $error("done set without cause");

  // The completion condition counts once when it appears, not while it stays.
  sequence s_done_rise;
    !state_report_select && done_now && !$past(done_now);
  endsequence

  property p_done_edge;
    @(posedge clk) disable iff (rst)
    s_done_rise |=> flags_q[CHGEVT_BIT_DONE];
  endproperty
  a_done_edge: assert property (p_done_edge) else $error("done lost");

  property p_indet_edges;
    @(posedge clk) disable iff (rst)
    $changed(input_source_valid) |=> flags_q[CHGEVT_BIT_INDET];
  endproperty
  a_indet_edges: assert property (p_indet_edges) else $error("input edge lost");

  property p_battery_presence_event_edges;
    @(posedge clk) disable iff (rst)
    $changed(battery_above_trickle) |=> flags_q[CHGEVT_BIT_BATTERY_PRESENCE_EVENT];
  endproperty
  a_battery_presence_event_edges: assert property (p_battery_presence_event_edges) else $error("battery edge lost");

  property p_ilim_sets;
    @(posedge clk) disable iff (rst)
    input_current_limit |=> flags_q[CHGEVT_BIT_ILIM];
  endproperty
  a_ilim_sets: assert property (p_ilim_sets) else $error("ilim flag not set");

  property p_inov_sets;
    @(posedge clk) disable iff (rst)
    input_overvoltage |=> flags_q[CHGEVT_BIT_INOV];
  endproperty
  a_inov_sets: assert property (p_inov_sets) else $error("inov flag not set");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
    !flags_q[0] && !mask_q[0];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_read_clears;
    @(posedge clk) disable iff (rst)
    s_read_flags ##0 (events == 8'h00) |=> (flags_q == 8'h00) && (reg_rdata == $past(flags_q));
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  // Without a read of the flag register no set flag may drop.
  property p_flags_hold;
    @(posedge clk) disable iff (rst)
    !rd_flags |=> (flags_q & $past(flags_q)) == $past(flags_q);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flag lost");

  property p_mask_write;
    @(posedge clk) disable iff (rst)
    reg_wr && (reg_addr == CHGEVT_ADDR_MASK) |=> mask_q == ($past(reg_wdata) & CHGEVT_IMPL_BITS);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_irq;
    @(posedge clk) disable iff (rst)
    (|(events & ~mask_q)) && !(reg_wr && (reg_addr == CHGEVT_ADDR_MASK))
    |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_irq_masked;
    @(posedge clk) disable iff (rst)
    (mask_q == CHGEVT_IMPL_BITS) |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq");
endmodule // chgevt_flags
`default_nettype wire

/* bench/charger_event_flags_tb_top.sv */
// Self-checking testbench for the charger event flag and mask registers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module charger_event_flags_tb_top;
  import chgevt_pkg::*;
  localparam logic [7:0] F = CHGEVT_ADDR_FLAGS;
  localparam logic [7:0] M = CHGEVT_ADDR_MASK;
  logic clk = 1'b0, rst = 1'b1, rd_s = 1'b0, wr_s = 1'b0, sel = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic [3:0] lv = 4'h0, st = 4'h0;
  logic flt = 1'b0, eoc = 1'b0, src = 1'b0, trk = 1'b0, irq;
  int err_count = 0, n_checks = 0;
  always #5 clk = ~clk;
  chgevt_flags DUT (.clk(clk), .rst(rst), .reg_addr(addr), .reg_rd(rd_s),
    .reg_wr(wr_s), .reg_wdata(wd), .reg_rdata(rdata),
    .battery_overvoltage(lv[0]), .battery_temp_fault(lv[1]),
    .battery_above_float(flt), .charge_current_below_eoc(eoc),
    .charger_state_field(st), .state_report_select(sel),
    .input_source_valid(src), .battery_above_trickle(trk),
    .input_current_limit(lv[2]), .input_overvoltage(lv[3]), .irq(irq));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobes drop and one idle edge passes, so tasks may follow back to back.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd_s = 1'b1;
    cyc(1);
    rd_s = 1'b0;
    `CHK(rdata, e)
    cyc(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr_s = 1'b1;
    cyc(1);
    wr_s = 1'b0;
    cyc(1);
  endtask
  task automatic t_regs;
    `CHK(irq, 1'b0)
    rd(F, CHGEVT_FLAGS_RESET);
    rd(M, CHGEVT_MASK_RESET);
    wr(M, 8'hFF);
    rd(M, CHGEVT_IMPL_BITS);
    wr(F, 8'hFF);
    rd(F, 8'h00);
    wr(M, 8'h00);
    rd(8'h55, 8'h00);
  endtask
  task automatic t_level;
    int b;
    for (int i = 0; i < 4; i++) begin
      for (int m = 0; m < 2; m++) begin
        b = (i < 2) ? i + 1 : i + 4;
        wr(M, m[0] ? (8'h01 << b) : 8'h00);
        lv[i] = 1'b1;
        cyc(1);
        lv[i] = 1'b0;
        cyc(1);
        `CHK(irq, ~m[0])
        rd(F, 8'h01 << b);
        rd(F, 8'h00);
        `CHK(irq, 1'b0)
      end
    end
    wr(M, 8'h00);
  endtask
  task automatic t_edges;
    src = 1'b1;
    cyc(3);
    rd(F, 8'h10);
    src = 1'b0;
    cyc(3);
    rd(F, 8'h10);
    trk = 1'b1;
    cyc(3);
    rd(F, 8'h20);
    trk = 1'b0;
    cyc(3);
    rd(F, 8'h20);
    cyc(3);
    rd(F, 8'h00);
  endtask
  task automatic t_done;
    flt = 1'b1;
    cyc(3);
    rd(F, 8'h00);
    flt = 1'b0;
    eoc = 1'b1;
    cyc(3);
    rd(F, 8'h00);
    flt = 1'b1;
    cyc(3);
    rd(F, 8'h08);
    st = 4'h7;
    cyc(3);
    rd(F, 8'h00);
    sel = 1'b1;
    st = 4'hA;
    cyc(3);
    rd(F, 8'h08);
    cyc(3);
    rd(F, 8'h00);
  endtask
  // An event seen in the same cycle as the clearing read must survive.
  // The event is gone before the next edge, so only the read edge can set it.
  task automatic t_race;
    addr = F;
    rd_s = 1'b1;
    lv[0] = 1'b1;
    cyc(1);
    rd_s = 1'b0;
    lv[0] = 1'b0;
    `CHK(rdata, 8'h00)
    cyc(1);
    rd(F, 8'h02);
    rd(F, 8'h00);
  endtask
  // A mid-run reset must drop flags, mask and the interrupt together.
  task automatic t_reset;
    wr(M, 8'h04);
    lv[3] = 1'b1;
    cyc(1);
    lv[3] = 1'b0;
    `CHK(irq, 1'b1)
    rst = 1'b1;
    cyc(1);
    `CHK(irq, 1'b0)
    `CHK(rdata, 8'h00)
    cyc(2);
    rst = 1'b0;
    `CHK(irq, 1'b0)
    rd(F, CHGEVT_FLAGS_RESET);
    rd(M, CHGEVT_MASK_RESET);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    err_count++;
    end_sim();
  end
  initial begin
    cyc(3);
    rst = 1'b0;
    t_regs();
    t_level();
    t_reset();
    t_edges();
    t_done();
    t_race();
    end_sim();
  end
endmodule // charger_event_flags_tb_top
`default_nettype wire
